// ==== common/cowc_consts.svh ====
// register offsets, field positions, reset values and mode codes of the
// compare output and waveform control block; assumes nothing else.
`ifndef COWC_CONSTS_SVH
`define COWC_CONSTS_SVH

// byte addresses on the register bus
`define COWC_OFF_CTRL 8'h90
`define COWC_OFF_HIGH 8'h94
`define COWC_OFF_STAT 8'h98

// output wave control fields
`define COWC_A_MODE_MSB 7
`define COWC_A_MODE_LSB 6
`define COWC_B_MODE_MSB 5
`define COWC_B_MODE_LSB 4
`define COWC_RESV_MSB 3
`define COWC_RESV_LSB 2
`define COWC_WAVE_LO_MSB 1
`define COWC_WAVE_LO_LSB 0

// second control fields (high wave mode bits)
`define COWC_WAVE_HI_MSB 4
`define COWC_WAVE_HI_LSB 3

// status fields
`define COWC_ST_PIN_A 0
`define COWC_ST_PIN_B 1
`define COWC_ST_OVR_A 2
`define COWC_ST_OVR_B 3
`define COWC_ST_CLS_MSB 6
`define COWC_ST_CLS_LSB 4

// reset values
`define COWC_MODE_RST 2'h0
`define COWC_WAVE_RST 2'h0
`define COWC_PIN_RST 1'h0

// wave mode codes
`define COWC_WGM_PC8 4'h1
`define COWC_WGM_PC9 4'h2
`define COWC_WGM_PC10 4'h3
`define COWC_WGM_FAST8 4'h5
`define COWC_WGM_FAST9 4'h6
`define COWC_WGM_FAST10 4'h7
`define COWC_WGM_PFC_ICR 4'h8
`define COWC_WGM_PFC_OCR 4'h9
`define COWC_WGM_PC_ICR 4'hA
`define COWC_WGM_PC_OCR 4'hB
`define COWC_WGM_FAST_ICR 4'hE
`define COWC_WGM_FAST_OCR 4'hF

`endif

// ==== common/cowc_pkg.sv ====
// types and mode decoding shared by the compare output block;
// assumes the constants header is on the include path.
`include "cowc_consts.svh"

package cowc_pkg;

  typedef enum logic [2:0] {
    COWC_CLS_NONPWM = 3'h1,
    COWC_CLS_FAST = 3'h2,
    COWC_CLS_PHASE = 3'h4
  } cowc_wave_class_t;

  typedef enum logic [1:0] {
    COWC_OM_OFF = 2'h0,
    COWC_OM_TOGGLE = 2'h1,
    COWC_OM_CLEAR = 2'h2,
    COWC_OM_SET = 2'h3
  } cowc_out_mode_t;

  function automatic cowc_wave_class_t cowc_classify(input logic [3:0] wm);
    case (wm)
      `COWC_WGM_FAST8, `COWC_WGM_FAST9, `COWC_WGM_FAST10,
      `COWC_WGM_FAST_ICR, `COWC_WGM_FAST_OCR: return COWC_CLS_FAST;
      `COWC_WGM_PC8, `COWC_WGM_PC9, `COWC_WGM_PC10, `COWC_WGM_PFC_ICR,
      `COWC_WGM_PFC_OCR, `COWC_WGM_PC_ICR, `COWC_WGM_PC_OCR: return COWC_CLS_PHASE;
      default: return COWC_CLS_NONPWM;
    endcase
  endfunction

  // modes in which toggle on match drives channel a in the pwm families
  function automatic logic cowc_toggle_ok(input logic [3:0] wm);
    return (wm == `COWC_WGM_FAST_ICR) || (wm == `COWC_WGM_FAST_OCR) ||
           (wm == `COWC_WGM_PFC_OCR) || (wm == `COWC_WGM_PC_OCR);
  endfunction

endpackage

// ==== design/cowc_wb_slave.sv ====
// classic wishbone slave front end of the compare output block;
// assumes a master that holds its request until it sees ack.
`timescale 1ns/100ps
`include "cowc_consts.svh"

module cowc_wb_slave (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // register file side
  input wire logic [31:0] rd_data_i,
  output logic wr_en_o
);

  logic req;

  assign req = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr_en_o = req && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'h0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= wb_we_i ? 32'h0 : rd_data_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

endmodule // cowc_wb_slave

// ==== design/cowc_chan_out.sv ====
// one compare output channel: pin level and pin takeover;
// assumes one-cycle match, bottom and top indications from the counter.
`timescale 1ns/100ps
`include "cowc_consts.svh"

module cowc_chan_out #(
  parameter bit IS_CHAN_A = 1'h1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic [1:0] mode_i,
  input wire logic [3:0] wave_mode_i,
  // counter events
  input wire logic match_i,
  input wire logic at_top_i,
  input wire logic count_down_i,
  input wire logic at_bottom_i,
  // pin side
  output logic pin_o,
  output logic override_o
);

  cowc_pkg::cowc_wave_class_t cls;
  logic tog_ok;
  logic next_pin;
  logic next_override;

  assign cls = cowc_pkg::cowc_classify(wave_mode_i);
  assign tog_ok = IS_CHAN_A && cowc_pkg::cowc_toggle_ok(wave_mode_i);

  always_comb begin
    case (mode_i)
      cowc_pkg::COWC_OM_OFF: next_override = 1'h0;
      cowc_pkg::COWC_OM_TOGGLE: next_override = (cls == cowc_pkg::COWC_CLS_NONPWM) || tog_ok;
      default: next_override = 1'h1;
    endcase
  end

  always_comb begin
    next_pin = pin_o;
    case (cls)
      cowc_pkg::COWC_CLS_NONPWM: begin
        if (match_i) begin
          case (mode_i)
            cowc_pkg::COWC_OM_TOGGLE: next_pin = !pin_o;
            cowc_pkg::COWC_OM_CLEAR: next_pin = 1'h0;
            cowc_pkg::COWC_OM_SET: next_pin = 1'h1;
            default: next_pin = pin_o;
          endcase
        end
      end
      cowc_pkg::COWC_CLS_FAST: begin
        case (mode_i)
          cowc_pkg::COWC_OM_TOGGLE: if (tog_ok && match_i) next_pin = !pin_o;
          // bottom wins; a match at top is dropped
          cowc_pkg::COWC_OM_CLEAR: begin
            if (at_bottom_i) next_pin = 1'h1;
            else if (match_i && !at_top_i) next_pin = 1'h0;
          end
          cowc_pkg::COWC_OM_SET: begin
            if (at_bottom_i) next_pin = 1'h0;
            else if (match_i && !at_top_i) next_pin = 1'h1;
          end
          default: next_pin = pin_o;
        endcase
      end
      cowc_pkg::COWC_CLS_PHASE: begin
        case (mode_i)
          cowc_pkg::COWC_OM_TOGGLE: if (tog_ok && match_i) next_pin = !pin_o;
          cowc_pkg::COWC_OM_CLEAR: if (match_i) next_pin = count_down_i;
          cowc_pkg::COWC_OM_SET: if (match_i) next_pin = !count_down_i;
          default: next_pin = pin_o;
        endcase
      end
      default: next_pin = pin_o;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pin_o <= `COWC_PIN_RST;
    end else begin
      pin_o <= next_pin;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      override_o <= 1'h0;
    end else begin
      override_o <= next_override;
    end
  end

endmodule // cowc_chan_out

// ==== design/cowc_top.sv ====
// compare output and waveform control block of a 16-bit timer: control
// registers on classic wishbone, two compare output channels.
// assumes the counter supplies one-cycle match, top and bottom indications
// and a count direction level, all synchronous to sys_clk_i.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
`include "cowc_consts.svh"

module cowc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // counter events
  input wire logic match_a_i,
  input wire logic match_b_i,
  input wire logic a_at_top_i,
  input wire logic b_at_top_i,
  input wire logic count_down_i,
  input wire logic at_bottom_i,
  // pin logic
  output logic chan_a_compare_pin_o,
  output logic chan_a_override_o,
  output logic chan_b_compare_pin_o,
  output logic chan_b_override_o,
  // to counter
  output logic [3:0] wave_mode_select_o
);

  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic [1:0] wave_lo;
  logic [1:0] wave_hi;
  logic [3:0] wave_mode;
  logic wr_en;
  logic [31:0] rd_data;
  cowc_pkg::cowc_wave_class_t cls;

  assign wave_mode = {wave_hi, wave_lo};
  assign wave_mode_select_o = wave_mode;
  assign cls = cowc_pkg::cowc_classify(wave_mode);

  cowc_wb_slave u_bus (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rd_data_i(rd_data),
    .wr_en_o(wr_en)
  );

  // output wave control register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      chan_a_output_mode <= `COWC_MODE_RST;
      chan_b_output_mode <= `COWC_MODE_RST;
      wave_lo <= `COWC_WAVE_RST;
    end else if (wr_en && wb_adr_i == `COWC_OFF_CTRL) begin
      chan_a_output_mode <= wb_dat_i[`COWC_A_MODE_MSB:`COWC_A_MODE_LSB];
      chan_b_output_mode <= wb_dat_i[`COWC_B_MODE_MSB:`COWC_B_MODE_LSB];
      wave_lo <= wb_dat_i[`COWC_WAVE_LO_MSB:`COWC_WAVE_LO_LSB];
    end
  end

  // high wave bits of the second control register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wave_hi <= `COWC_WAVE_RST;
    end else if (wr_en && wb_adr_i == `COWC_OFF_HIGH) begin
      wave_hi <= wb_dat_i[`COWC_WAVE_HI_MSB:`COWC_WAVE_HI_LSB];
    end
  end

  // read mux; unmapped and unused bits read zero
  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `COWC_OFF_CTRL: begin
        rd_data[`COWC_A_MODE_MSB:`COWC_A_MODE_LSB] = chan_a_output_mode;
        rd_data[`COWC_B_MODE_MSB:`COWC_B_MODE_LSB] = chan_b_output_mode;
        rd_data[`COWC_WAVE_LO_MSB:`COWC_WAVE_LO_LSB] = wave_lo;
      end
      `COWC_OFF_HIGH: begin
        rd_data[`COWC_WAVE_HI_MSB:`COWC_WAVE_HI_LSB] = wave_hi;
      end
      `COWC_OFF_STAT: begin
        rd_data[`COWC_ST_PIN_A] = chan_a_compare_pin_o;
        rd_data[`COWC_ST_PIN_B] = chan_b_compare_pin_o;
        rd_data[`COWC_ST_OVR_A] = chan_a_override_o;
        rd_data[`COWC_ST_OVR_B] = chan_b_override_o;
        rd_data[`COWC_ST_CLS_MSB:`COWC_ST_CLS_LSB] = cls;
      end
      default: rd_data = 32'h0;
    endcase
  end

  cowc_chan_out #(
    .IS_CHAN_A(1'h1)
  ) u_chan_a (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .mode_i(chan_a_output_mode),
    .wave_mode_i(wave_mode),
    .match_i(match_a_i),
    .at_top_i(a_at_top_i),
    .count_down_i(count_down_i),
    .at_bottom_i(at_bottom_i),
    .pin_o(chan_a_compare_pin_o),
    .override_o(chan_a_override_o)
  );

  cowc_chan_out #(
    .IS_CHAN_A(1'h0)
  ) u_chan_b (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .mode_i(chan_b_output_mode),
    .wave_mode_i(wave_mode),
    .match_i(match_b_i),
    .at_top_i(b_at_top_i),
    .count_down_i(count_down_i),
    .at_bottom_i(at_bottom_i),
    .pin_o(chan_b_compare_pin_o),
    .override_o(chan_b_override_o)
  );

  // checks on the register file and on the channel outputs
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic is_nonpwm;
  logic is_fast;
  logic is_phase;
  logic [1:0] ma;
  logic [1:0] mb;

  assign is_nonpwm = (cls == cowc_pkg::COWC_CLS_NONPWM);
  assign is_fast = (cls == cowc_pkg::COWC_CLS_FAST);
  assign is_phase = (cls == cowc_pkg::COWC_CLS_PHASE);
  assign ma = chan_a_output_mode;
  assign mb = chan_b_output_mode;

  sequence s_ctrl_write;
    wr_en && wb_adr_i == `COWC_OFF_CTRL;
  endsequence

  sequence s_ctrl_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `COWC_OFF_CTRL;
  endsequence

  sequence s_fast_clear_match_a;
    is_fast && ma == cowc_pkg::COWC_OM_CLEAR && match_a_i && !a_at_top_i && !at_bottom_i;
  endsequence

  sequence s_fast_set_top_a;
    is_fast && ma == cowc_pkg::COWC_OM_SET && match_a_i && a_at_top_i && !at_bottom_i;
  endsequence

  a_ctrl_field_store: assert property (
    s_ctrl_write |=> ma == $past(wb_dat_i[7:6]) && mb == $past(wb_dat_i[5:4])
      && wave_lo == $past(wb_dat_i[1:0]))
    else $error("control write not stored in its fields");

  a_ctrl_resv_zero: assert property (
    s_ctrl_read |=> wb_ack_o && wb_dat_o[3:2] == 2'h0 && wb_dat_o[7:6] == ma)
    else $error("control read returns wrong fields");

  a_wave_join: assert property (
    (wr_en && wb_adr_i == `COWC_OFF_HIGH) |=> wave_mode_select_o[3:2] == $past(wb_dat_i[4:3]))
    else $error("high wave bits not joined into the mode");

  a_mode_off_port: assert property (
    (ma == cowc_pkg::COWC_OM_OFF) ##1 (ma == cowc_pkg::COWC_OM_OFF) |-> !chan_a_override_o)
    else $error("channel a takes the pin with mode off");

  a_mode_on_takes: assert property (
    (mb[1] && $stable(mb)) |=> chan_b_override_o)
    else $error("channel b does not take the pin");

  a_nonpwm_toggle: assert property (
    (is_nonpwm && ma == cowc_pkg::COWC_OM_TOGGLE && match_a_i)
      |=> chan_a_compare_pin_o != $past(chan_a_compare_pin_o))
    else $error("non-pwm toggle missed");

  a_nonpwm_clear_set: assert property (
    (is_nonpwm && mb[1] && match_b_i) |=> chan_b_compare_pin_o == $past(mb[0]))
    else $error("non-pwm clear or set wrong");

  a_fast_b_toggle_off: assert property (
    (!is_nonpwm && mb == cowc_pkg::COWC_OM_TOGGLE) ##1 $stable(mb) && $stable(cls)
      |-> !chan_b_override_o)
    else $error("channel b connected in pwm toggle");

  a_fast_a_toggle: assert property (
    (is_fast && ma == cowc_pkg::COWC_OM_TOGGLE && match_a_i
      && !cowc_pkg::cowc_toggle_ok(wave_mode)) |=> $stable(chan_a_compare_pin_o))
    else $error("fast pwm toggle outside modes 14 and 15");

  a_fast_clear_match: assert property (
    s_fast_clear_match_a |=> !chan_a_compare_pin_o)
    else $error("fast pwm clear on match missed");

  a_fast_bottom_set: assert property (
    (is_fast && mb == cowc_pkg::COWC_OM_CLEAR && at_bottom_i) |=> chan_b_compare_pin_o)
    else $error("fast pwm set at bottom missed");

  a_fast_top_ignore: assert property (
    s_fast_set_top_a |=> chan_a_compare_pin_o == $past(chan_a_compare_pin_o))
    else $error("fast pwm match at top not ignored");

  a_phase_toggle_gate: assert property (
    (is_phase && ma == cowc_pkg::COWC_OM_TOGGLE && match_a_i
      && cowc_pkg::cowc_toggle_ok(wave_mode)) |=> $changed(chan_a_compare_pin_o))
    else $error("phase pwm toggle missed");

  a_phase_clear_dir: assert property (
    (is_phase && ma == cowc_pkg::COWC_OM_CLEAR && match_a_i)
      |=> chan_a_compare_pin_o == $past(count_down_i))
    else $error("phase pwm clear direction wrong");

  a_phase_set_dir: assert property (
    (is_phase && mb == cowc_pkg::COWC_OM_SET && match_b_i)
      |=> chan_b_compare_pin_o == !$past(count_down_i))
    else $error("phase pwm set direction wrong");

  a_class_onehot: assert property (
    $onehot(cls) && (wave_mode == 4'h0 || wave_mode == 4'h4 || wave_mode == 4'hC) |-> is_nonpwm)
    else $error("wave mode class decode wrong");

  sequence s_high_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `COWC_OFF_HIGH;
  endsequence

  sequence s_stat_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `COWC_OFF_STAT;
  endsequence

  sequence s_fast_clear_top_b;
    is_fast && mb == cowc_pkg::COWC_OM_CLEAR && match_b_i && b_at_top_i && !at_bottom_i;
  endsequence

  a_wave_low_join: assert property (
    s_ctrl_write |=> wave_mode_select_o[1:0] == $past(wb_dat_i[1:0]))
    else $error("low wave bits not joined into the mode");

  a_high_readback: assert property (
    s_high_read |=> wb_ack_o && wb_dat_o == {27'h0, wave_hi, 3'h0})
    else $error("high wave read returns wrong bits");

  a_stat_class_read: assert property (
    s_stat_read |=> wb_dat_o[6:4] == $past(cls) && wb_dat_o[31:7] == 25'h0)
    else $error("status read returns wrong class");

  a_unmapped_reads_zero: assert property (
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i != `COWC_OFF_CTRL
      && wb_adr_i != `COWC_OFF_HIGH && wb_adr_i != `COWC_OFF_STAT) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  a_ctrl_sel_guard: assert property (
    (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0])
      |=> $stable(ma) && $stable(mb) && $stable(wave_lo))
    else $error("control write without byte lane stored");

  a_ctrl_fields_hold: assert property (
    !(wr_en && wb_adr_i == `COWC_OFF_CTRL)
      |=> $stable(ma) && $stable(mb) && $stable(wave_lo))
    else $error("control fields changed without a write");

  a_mode_off_b: assert property (
    (mb == cowc_pkg::COWC_OM_OFF) |=> !chan_b_override_o)
    else $error("channel b takes the pin with mode off");

  a_mode_on_a: assert property (
    ma[1] |=> chan_a_override_o)
    else $error("channel a does not take the pin");

  a_nonpwm_toggle_b: assert property (
    (is_nonpwm && mb == cowc_pkg::COWC_OM_TOGGLE && match_b_i)
      |=> $changed(chan_b_compare_pin_o))
    else $error("non-pwm toggle on channel b missed");

  a_nonpwm_level_a: assert property (
    (is_nonpwm && ma[1] && match_a_i) |=> chan_a_compare_pin_o == $past(ma[0]))
    else $error("non-pwm clear or set on channel a wrong");

  a_fast_toggle_ok: assert property (
    (is_fast && ma == cowc_pkg::COWC_OM_TOGGLE && match_a_i
      && cowc_pkg::cowc_toggle_ok(wave_mode)) |=> $changed(chan_a_compare_pin_o))
    else $error("fast pwm toggle in modes 14 and 15 missed");

  a_fast_bottom_clear: assert property (
    (is_fast && ma == cowc_pkg::COWC_OM_SET && at_bottom_i) |=> !chan_a_compare_pin_o)
    else $error("fast pwm clear at bottom missed");

  a_fast_bottom_wins: assert property (
    (is_fast && mb == cowc_pkg::COWC_OM_CLEAR && at_bottom_i && match_b_i)
      |=> chan_b_compare_pin_o)
    else $error("fast pwm bottom action lost to a match");

  a_fast_top_b: assert property (
    s_fast_clear_top_b |=> $stable(chan_b_compare_pin_o))
    else $error("fast pwm match at top not ignored on channel b");

  a_phase_toggle_off: assert property (
    (is_phase && ma == cowc_pkg::COWC_OM_TOGGLE && match_a_i
      && !cowc_pkg::cowc_toggle_ok(wave_mode)) |=> $stable(chan_a_compare_pin_o))
    else $error("phase pwm toggle outside modes 9 and 11");

  a_phase_b_toggle: assert property (
    (is_phase && mb == cowc_pkg::COWC_OM_TOGGLE && match_b_i)
      |=> $stable(chan_b_compare_pin_o))
    else $error("phase pwm toggle drove channel b");

  a_phase_clear_b: assert property (
    (is_phase && mb == cowc_pkg::COWC_OM_CLEAR && match_b_i)
      |=> chan_b_compare_pin_o == $past(count_down_i))
    else $error("phase pwm clear direction wrong on channel b");

  a_phase_set_a: assert property (
    (is_phase && ma == cowc_pkg::COWC_OM_SET && match_a_i)
      |=> chan_a_compare_pin_o == !$past(count_down_i))
    else $error("phase pwm set direction wrong on channel a");

  a_pin_idle_a: assert property (
    (!match_a_i && !at_bottom_i) |=> $stable(chan_a_compare_pin_o))
    else $error("channel a pin moved without an event");

  a_pin_idle_b: assert property (
    (!match_b_i && !at_bottom_i) |=> $stable(chan_b_compare_pin_o))
    else $error("channel b pin moved without an event");

endmodule // cowc_top

// ==== bench/cowc_port_pin_model.sv ====
// port pin logic beside one compare output: direction bit, port data and
// the extra port d bit 2 gate. assumes a pad pulled high when undriven.
`timescale 1ns/100ps

module cowc_port_pin_model #(
  parameter bit NEEDS_PORT_D2 = 1'h0
) (
  // from the compare block
  input wire logic compare_pin_i,
  input wire logic override_i,
  // port registers
  input wire logic dir_i,
  input wire logic port_data_i,
  input wire logic port_d_bit2_enable_i,
  // pad
  output logic pad_o
);
  logic drive_en;
  logic drive_val;

  // driver stays off without the direction bit
  assign drive_en = dir_i
    && (!override_i || !NEEDS_PORT_D2 || port_d_bit2_enable_i);
  assign drive_val = override_i ? compare_pin_i : port_data_i;
  assign pad_o = drive_en ? drive_val : 1'h1;
endmodule // cowc_port_pin_model

// ==== bench/compare_output_waveform_control_tb_top.sv ====
// self-checking bench of the compare output block: random modes and counter
// events against a bench model. assumes cowc_top and the port pin model.
`timescale 1ns/100ps
`include "cowc_consts.svh"

module compare_output_waveform_control_tb_top;
  logic sys_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic match_a_i = 1'h0;
  logic match_b_i = 1'h0;
  logic a_at_top_i = 1'h0;
  logic b_at_top_i = 1'h0;
  logic count_down_i = 1'h0;
  logic at_bottom_i = 1'h0;
  logic pin_a, ovr_a, pin_b, ovr_b;
  logic [3:0] wave_mode_select_o;
  logic [4:0] port_ctl = 5'h00;
  logic pad_a, pad_b;
  logic [31:0] lfsr = 32'h3D82;
  logic exp_a = 1'h0;
  logic exp_b = 1'h0;
  int n_mismatch = 0;
  int n_compared = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  cowc_top u_cowc_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .match_a_i(match_a_i),
    .match_b_i(match_b_i), .a_at_top_i(a_at_top_i), .b_at_top_i(b_at_top_i),
    .count_down_i(count_down_i), .at_bottom_i(at_bottom_i), .chan_a_compare_pin_o(pin_a),
    .chan_a_override_o(ovr_a), .chan_b_compare_pin_o(pin_b), .chan_b_override_o(ovr_b),
    .wave_mode_select_o(wave_mode_select_o));

  cowc_port_pin_model #(.NEEDS_PORT_D2(1'h0)) u_cowc_port_pin_model (.compare_pin_i(pin_a),
    .override_i(ovr_a), .dir_i(port_ctl[0]), .port_data_i(port_ctl[1]),
    .port_d_bit2_enable_i(port_ctl[4]), .pad_o(pad_a));
  cowc_port_pin_model #(.NEEDS_PORT_D2(1'h1)) u_cowc_port_pin_model_b (.compare_pin_i(pin_b),
    .override_i(ovr_b), .dir_i(port_ctl[2]), .port_data_i(port_ctl[3]),
    .port_d_bit2_enable_i(port_ctl[4]), .pad_o(pad_b));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // 0 non-pwm, 1 fast, 2 phase families
  function automatic int wclass(input logic [3:0] wm);
    case (wm)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return 1;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: return 2;
      default: return 0;
    endcase
  endfunction

  function automatic logic ovr(input logic [1:0] m, input logic [3:0] wm, input bit is_a);
    logic tog_ok;
    tog_ok = (wclass(wm) == 0) || (is_a && (wclass(wm) == 1 ? (wm >= 4'hE) :
      (wm == 4'h9 || wm == 4'hB)));
    return (m != 2'h0) && (m != 2'h1 || tog_ok);
  endfunction

  function automatic logic nxt(input logic [1:0] m, input logic [3:0] wm, input bit is_a,
      input logic pin, input logic match, input logic top, input logic down, input logic bot);
    if (!ovr(m, wm, is_a)) return pin;
    if (m == 2'h1) return match ? ~pin : pin;
    case (wclass(wm))
      0: return match ? m[0] : pin;
      1: return bot ? ~m[0] : ((match && !top) ? m[0] : pin);
      default: return match ? (m[0] ^ down) : pin;
    endcase
  endfunction

  // pad level from direction bit, port data and the port d bit 2 gate
  function automatic logic pad_exp(input logic [1:0] pc, input logic own, input logic pin,
      input logic gate);
    if (!pc[0] || (own && !gate)) return 1'h1;
    return own ? pin : pc[1];
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
      input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    check("bus ack wait", 32'h2, 32'(n));
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic run_round(input logic [3:0] wm, input logic [7:0] ctrl);
    logic [31:0] rd, ev;
    logic [1:0] ma, mb;
    logic oa, ob;
    ma = ctrl[7:6];
    mb = ctrl[5:4];
    oa = ovr(ma, wm, 1'h1);
    ob = ovr(mb, wm, 1'h0);
    ev = rnd();
    port_ctl <= ev[12:8];
    wb_xfer(1'h1, `COWC_OFF_HIGH, {27'h0, wm[3:2], 3'h0}, 4'hF, rd);
    wb_xfer(1'h1, `COWC_OFF_CTRL, {24'h0, ctrl[7:2], wm[1:0]}, 4'hF, rd);
    wb_xfer(1'h0, `COWC_OFF_CTRL, 32'h0, 4'hF, rd);
    check("ctrl readback", {24'h0, ctrl[7:4], 2'h0, wm[1:0]}, rd);
    wb_xfer(1'h0, `COWC_OFF_HIGH, 32'h0, 4'hF, rd);
    check("high readback", {27'h0, wm[3:2], 3'h0}, rd);
    @(negedge sys_clk_i);
    check("wave mode", 32'(wm), 32'(wave_mode_select_o));
    check("override a", 32'(oa), 32'(ovr_a));
    check("override b", 32'(ob), 32'(ovr_b));
    repeat (16) begin
      ev = rnd();
      @(posedge sys_clk_i);
      match_a_i <= ev[0];
      match_b_i <= ev[1];
      a_at_top_i <= ev[2];
      b_at_top_i <= ev[3];
      count_down_i <= ev[4];
      at_bottom_i <= ev[5] & ev[6];
      exp_a = nxt(ma, wm, 1'h1, exp_a, ev[0], ev[2], ev[4], ev[5] & ev[6]);
      exp_b = nxt(mb, wm, 1'h0, exp_b, ev[1], ev[3], ev[4], ev[5] & ev[6]);
      @(posedge sys_clk_i);
      match_a_i <= 1'h0;
      match_b_i <= 1'h0;
      at_bottom_i <= 1'h0;
      @(negedge sys_clk_i);
      check("pin a", 32'(exp_a), 32'(pin_a));
      check("pin b", 32'(exp_b), 32'(pin_b));
      check("pad a", 32'(pad_exp(port_ctl[1:0], oa, exp_a, 1'h1)), 32'(pad_a));
      check("pad b", 32'(pad_exp(port_ctl[3:2], ob, exp_b, port_ctl[4])), 32'(pad_b));
    end
    wb_xfer(1'h0, `COWC_OFF_STAT, 32'h0, 4'hF, rd);
    ev = {25'h0, 3'(1 << wclass(wm)), ovr(mb, wm, 1'h0), ovr(ma, wm, 1'h1), exp_b, exp_a};
    check("status", ev, rd);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [31:0] rd, t, u;
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'h1;
    @(posedge sys_clk_i);
    wb_xfer(1'h0, `COWC_OFF_CTRL, 32'h0, 4'hF, rd);
    check("ctrl reset", 32'h0, rd);
    wb_xfer(1'h1, `COWC_OFF_CTRL, 32'hC0, 4'hE, rd);
    wb_xfer(1'h1, 8'hA0, 32'hFF, 4'hF, rd);
    wb_xfer(1'h0, 8'hA0, 32'h0, 4'hF, rd);
    check("unmapped", 32'h0, rd);
    wb_xfer(1'h0, `COWC_OFF_CTRL, 32'h0, 4'hF, rd);
    check("ctrl sel0 off", 32'h0, rd);
    $display("test bus corners done");
    // first sixteen rounds walk every wave mode, then random ones
    for (int r = 0; r < 48; r++) begin
      t = rnd();
      u = rnd();
      run_round(r < 16 ? 4'(r) : t[11:8], u[7:0]);
      $display("test round %0d done", r);
    end
    give_verdict();
  end
endmodule // compare_output_waveform_control_tb_top
